// File: logic/qdc_map.svh
// Constants for the queued DMA command sequencer
`ifndef QDC_MAP_SVH
`define QDC_MAP_SVH
`define QDC_TAG_W 5
`define QDC_CNT_W 16
`define QDC_ADDR_W 4
`define QDC_A_CTRL 4'h0
`define QDC_A_STATUS 4'h1
`define QDC_A_TAGCNT 4'h2
`define QDC_A_ERR 4'h3
`define QDC_CTRL_NIEN 0
`define QDC_CTRL_RELIE 1
`define QDC_CTRL_SRVIE 2
`define QDC_CTRL_DIROUT 3
`define QDC_ST_BSY 7
`define QDC_ST_DRQ 3
`define QDC_ST_REL 2
`define QDC_ST_SERV 4
`define QDC_ST_CD 1
`define QDC_ST_IO 0
`define QDC_ST_ERR 5
`endif

// File: logic/qdc_pkg.sv
// Types for the queued DMA command sequencer
`default_nettype none
package qdc_pkg;
    typedef enum logic [4:0] {
        QDC_IDLE = 5'h01,
        QDC_PREP = 5'h02,
        QDC_RDY_IRQ = 5'h04,
        QDC_XFER = 5'h08,
        QDC_REL_IDLE = 5'h10
    } qdc_state_t;
    typedef enum logic [1:0] {
        QDC_EXIT_IDLE = 2'h0,
        QDC_EXIT_REL_IDLE = 2'h1,
        QDC_EXIT_SERV = 2'h2
    } qdc_exit_t;
endpackage
`default_nettype wire

// File: logic/qdc_xfer_ctr.sv
// Byte counter for the DMA data phase
`timescale 1ns/1ns
`default_nettype none
`include "qdc_map.svh"
module qdc_xfer_ctr #(
    parameter int CNT_W = `QDC_CNT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [CNT_W-1:0] load_val,
    input wire logic step,
    output logic done
);
    logic [CNT_W-1:0] left_ff;
    logic [CNT_W-1:0] nxt_left;

    // Count down one per strobe; saturate at zero
    assign nxt_left = load ? load_val :
        (step && left_ff != '0) ? left_ff - {{(CNT_W-1){1'b0}}, 1'b1} : left_ff;
    assign done = (left_ff == '0);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            left_ff <= '0;
        end else begin
            left_ff <= nxt_left;
        end
    end
endmodule // qdc_xfer_ctr

// File: logic/qdc_dev.sv
// Device-side command-phase sequencer for overlapped and queued DMA commands
`timescale 1ns/1ns
`default_nettype none
`include "qdc_map.svh"
module qdc_dev
    import qdc_pkg::*;
#(
    parameter int TAG_W = `QDC_TAG_W,
    parameter int CNT_W = `QDC_CNT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`QDC_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic pkt_done,
    input wire logic overlapped,
    input wire logic service_cmd,
    input wire logic data_ready,
    input wire logic [TAG_W-1:0] cmd_tag,
    input wire logic [CNT_W-1:0] cmd_count,
    input wire logic cmd_done,
    input wire logic cmd_abort,
    input wire logic release_req,
    input wire logic other_released,
    input wire logic other_ready,
    input wire logic dma_ack,
    output logic intrq,
    output logic dmarq,
    output logic int_pending,
    output logic [4:0] state_out
);
    import qdc_pkg::*;

    qdc_state_t state_ff;
    qdc_state_t nxt_state;
    logic [3:0] ctrl_ff;
    logic bsy_ff, drq_ff, rel_ff, serv_ff, cd_ff, io_ff, err_ff, pend_ff, srv_irq_ff;
    logic nxt_bsy, nxt_drq, nxt_rel, nxt_serv, nxt_cd, nxt_io, nxt_err, nxt_pend;
    logic nxt_srv_irq;
    logic [TAG_W-1:0] tag_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic xfer_done;
    logic load_tag;
    // First preparation cycle after a packet; the packet strobe is gone by then
    logic fresh_pkt_ff;

    // Register decode
    wire nien = ctrl_ff[`QDC_CTRL_NIEN];
    wire rel_ie = ctrl_ff[`QDC_CTRL_RELIE];
    wire srv_ie = ctrl_ff[`QDC_CTRL_SRVIE];
    wire dir_out = ctrl_ff[`QDC_CTRL_DIROUT];
    wire wr_ctrl = reg_wr && reg_addr == `QDC_A_CTRL;
    wire rd_status = reg_rd && reg_addr == `QDC_A_STATUS;
    wire finish = cmd_done || cmd_abort;
    wire do_release = release_req || (overlapped && rel_ie && fresh_pkt_ff);
    wire [7:0] status_byte = {bsy_ff, 1'b0, err_ff, serv_ff, drq_ff, rel_ff, cd_ff, io_ff};

    // Counts DMA strobes so the data phase ends on its own byte count
    qdc_xfer_ctr #(.CNT_W(CNT_W)) u_ctr (
        .clk(clk),
        .rst_n(rst_n),
        .load(state_ff != QDC_XFER && nxt_state == QDC_XFER),
        .load_val(load_tag ? cmd_count : cnt_ff),
        .step(dma_ack && dmarq),
        .done(xfer_done)
    );

    // Sequencer; release is judged before data so an overlapped command lets the bus go
    always_comb begin
        nxt_state = state_ff;
        nxt_bsy = bsy_ff;
        nxt_drq = drq_ff;
        nxt_rel = rel_ff;
        nxt_serv = serv_ff;
        nxt_cd = cd_ff;
        nxt_io = io_ff;
        nxt_err = err_ff;
        nxt_pend = pend_ff;
        nxt_srv_irq = srv_irq_ff;
        case (state_ff)
            QDC_IDLE, QDC_REL_IDLE: begin
                if (pkt_done || service_cmd) begin
                    nxt_state = QDC_PREP;
                    nxt_bsy = 1'b1;
                    nxt_drq = 1'b0;
                    nxt_rel = 1'b0;
                    nxt_serv = 1'b0;
                    nxt_err = 1'b0;
                    nxt_srv_irq = service_cmd && srv_ie;
                end
            end
            QDC_PREP: begin
                if (srv_irq_ff) begin
                    nxt_state = QDC_RDY_IRQ;
                    nxt_srv_irq = 1'b1;
                    nxt_bsy = 1'b0;
                    nxt_drq = 1'b1;
                    nxt_cd = 1'b0;
                    nxt_io = dir_out;
                end else if (do_release || finish) begin
                    nxt_err = cmd_abort;
                    nxt_cd = 1'b1;
                    nxt_io = 1'b1;
                    nxt_rel = do_release;
                    nxt_serv = other_ready;
                    nxt_bsy = 1'b0;
                    nxt_drq = 1'b0;
                    nxt_pend = !nien;
                    nxt_state = (do_release || other_released || other_ready) ?
                        QDC_REL_IDLE : QDC_IDLE;
                end else if (data_ready) begin
                    nxt_pend = 1'b1;
                    nxt_bsy = 1'b0;
                    nxt_drq = 1'b1;
                    nxt_cd = 1'b0;
                    nxt_io = dir_out;
                    nxt_state = nien ? QDC_XFER : QDC_RDY_IRQ;
                end
            end
            QDC_RDY_IRQ: begin
                if (rd_status && srv_irq_ff) begin
                    nxt_state = QDC_PREP;
                    nxt_srv_irq = 1'b0;
                    nxt_bsy = 1'b1;
                    nxt_drq = 1'b0;
                end else if (rd_status) begin
                    nxt_pend = 1'b0;
                    nxt_state = QDC_XFER;
                end
            end
            QDC_XFER: begin
                if (xfer_done && !(dma_ack && dmarq)) begin
                    nxt_state = QDC_PREP;
                    nxt_bsy = 1'b1;
                    nxt_drq = 1'b0;
                end
            end
            default: begin
                nxt_state = QDC_IDLE;
            end
        endcase
    end

    // Tag and count latch on every entry to the data or interrupt-ready path
    // The direct jump to transfer loads the counter in the same cycle, so it bypasses cnt_ff
    assign load_tag = state_ff == QDC_PREP && nxt_state != QDC_PREP && !nxt_bsy && nxt_drq;

    // Status readback; status read drops a plain pending interrupt in idle
    assign nxt_rdata = (reg_addr == `QDC_A_CTRL) ? {4'h0, ctrl_ff} :
        (reg_addr == `QDC_A_STATUS) ? status_byte :
        (reg_addr == `QDC_A_TAGCNT) ? {{(8-TAG_W){1'b0}}, tag_ff} :
        (reg_addr == `QDC_A_ERR) ? {7'h00, err_ff} : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= QDC_IDLE;
            {bsy_ff, drq_ff, rel_ff, serv_ff, cd_ff, io_ff, err_ff} <= 7'h00;
            pend_ff <= 1'b0;
            srv_irq_ff <= 1'b0;
            fresh_pkt_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            {bsy_ff, drq_ff, rel_ff, serv_ff} <= {nxt_bsy, nxt_drq, nxt_rel, nxt_serv};
            {cd_ff, io_ff, err_ff, srv_irq_ff} <= {nxt_cd, nxt_io, nxt_err, nxt_srv_irq};
            pend_ff <= (rd_status && state_ff != QDC_PREP) ? 1'b0 : nxt_pend;
            fresh_pkt_ff <= (state_ff == QDC_IDLE || state_ff == QDC_REL_IDLE) && pkt_done;
        end
    end

    // Software port and captured command identity
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_ff <= 4'h0;
            rdata_ff <= 8'h00;
            tag_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= reg_wdata[3:0];
            end
            rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
            if (load_tag) begin
                tag_ff <= cmd_tag;
                cnt_ff <= cmd_count;
            end
        end
    end

    // INTRQ gated by nIEN so a pending flag never reaches the pin when masked
    // Ready-irq raises INTRQ by itself, since a service entry never sets the pending flag
    // In the idle states the pending flag alone drives the pin
    assign intrq = !nien && (state_ff == QDC_RDY_IRQ ||
        (pend_ff && (state_ff == QDC_IDLE || state_ff == QDC_REL_IDLE)));
    assign dmarq = (state_ff == QDC_XFER) && !xfer_done;
    assign int_pending = pend_ff;
    assign reg_rdata = rdata_ff;
    assign state_out = state_ff;

    chk_prep_bsy: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_PREP |-> bsy_ff && !drq_ff && !intrq)
        else $error("prep state not busy");
    chk_rdy_pins: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_RDY_IRQ |-> !bsy_ff && drq_ff && !cd_ff && io_ff == dir_out)
        else $error("ready-irq status wrong");
    chk_xfer_pins: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_XFER |-> !bsy_ff && drq_ff && !intrq && !cd_ff)
        else $error("transfer status wrong");
    chk_nien_mask: assert property (@(posedge clk) disable iff (!rst_n)
        nien |-> !intrq)
        else $error("intrq while masked");
    chk_ready_path: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_PREP && !srv_irq_ff && !do_release && !finish && data_ready && nien
        |=> state_ff == QDC_XFER && pend_ff)
        else $error("nien data path wrong");
    chk_irq_path: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_PREP && !srv_irq_ff && !do_release && !finish && data_ready && !nien
        |=> state_ff == QDC_RDY_IRQ && intrq)
        else $error("irq data path wrong");
    chk_status_ack: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_RDY_IRQ && rd_status && !srv_irq_ff |=> state_ff == QDC_XFER && !pend_ff)
        else $error("status read not honoured");
    chk_finish_bits: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_PREP && !srv_irq_ff && finish
        |=> !bsy_ff && cd_ff && io_ff && serv_ff == $past(other_ready) && pend_ff == !nien)
        else $error("completion status wrong");
    chk_xfer_back: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_XFER && xfer_done && !dmarq |=> state_ff == QDC_PREP)
        else $error("transfer did not end");

    // The checks below pin down the service, release and completion exits of preparation and the other states on their own.
    // They assume software leaves the control register alone while a
    // command is in flight, which the host protocol requires anyway.

    // An overlapped packet with release enabled lets the bus go at once
    chk_rel_on_pkt: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_PREP && !srv_irq_ff && fresh_pkt_ff && overlapped && rel_ie
        |=> state_ff == QDC_REL_IDLE && rel_ff && !bsy_ff)
        else $error("overlapped packet kept the bus");

    // A service interrupt request always goes to ready-irq first
    chk_srv_path: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_PREP && srv_irq_ff |=> state_ff == QDC_RDY_IRQ)
        else $error("service path wrong");

    // Tag and count follow the inputs seen at the latch
    chk_tag_load: assert property (@(posedge clk) disable iff (!rst_n)
        load_tag |=> tag_ff == $past(cmd_tag) && cnt_ff == $past(cmd_count))
        else $error("tag or count not latched");

    // Completion with an empty queue goes to plain idle
    chk_done_idle: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_PREP && !srv_irq_ff && finish && !do_release && !other_released
        && !other_ready |=> state_ff == QDC_IDLE && !rel_ff && !serv_ff)
        else $error("completion exit wrong");

    // Completion with a released command waiting goes to released-idle
    chk_done_relq: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_PREP && !srv_irq_ff && finish && !do_release && other_released
        && !other_ready |=> state_ff == QDC_REL_IDLE && !serv_ff && cd_ff && io_ff)
        else $error("released-queue exit wrong");

    // Completion with a command ready raises SERV with BSY clear
    chk_done_serv: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_PREP && !srv_irq_ff && finish && other_ready
        |=> serv_ff && !bsy_ff)
        else $error("serv not raised");

    // Release sets REL, C/D and I/O and honours the mask on pending
    chk_release_bits: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_PREP && !srv_irq_ff && do_release
        |=> state_ff == QDC_REL_IDLE && rel_ff && cd_ff && io_ff && !bsy_ff && pend_ff == !nien)
        else $error("release status wrong");

    // Ready-irq drives the pin whenever it is unmasked
    chk_rdy_intrq: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_RDY_IRQ && !nien |-> intrq)
        else $error("ready-irq without intrq");

    // Status read answering a service interrupt goes back to preparation
    chk_srv_return: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_RDY_IRQ && rd_status && srv_irq_ff |=> state_ff == QDC_PREP && bsy_ff)
        else $error("service return wrong");

    // Without a status read ready-irq holds
    chk_ready_hold: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_RDY_IRQ && !rd_status |=> state_ff == QDC_RDY_IRQ)
        else $error("ready-irq left early");

    // Transfer raises DMARQ and drives I/O by direction while units remain
    chk_xfer_dmarq: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_XFER && !xfer_done |-> dmarq && io_ff == dir_out)
        else $error("dmarq missing in transfer");

    // DMARQ never shows outside the transfer state
    chk_dmarq_only: assert property (@(posedge clk) disable iff (!rst_n)
        dmarq |-> state_ff == QDC_XFER)
        else $error("dmarq outside transfer");

    // Transfer holds until the counter runs out
    chk_xfer_stay: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_XFER && !xfer_done |=> state_ff == QDC_XFER)
        else $error("transfer left early");

    // A packet in idle enters preparation busy with DRQ clear
    chk_idle_prep: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == QDC_IDLE && pkt_done |=> state_ff == QDC_PREP && bsy_ff && !drq_ff)
        else $error("packet did not start preparation");

    // A pending flag under the mask never reaches the pin
    chk_pend_mask: assert property (@(posedge clk) disable iff (!rst_n)
        pend_ff && nien |-> !intrq)
        else $error("masked pending reached intrq");
endmodule // qdc_dev
`default_nettype wire

// File: sim/qdc_host_dma.sv
// Host DMA channel model that answers the device's DMA request
`timescale 1ns/1ns
`default_nettype none
module qdc_host_dma (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic armed,
    input wire logic slow,
    input wire logic dmarq,
    output logic dma_ack
);
    logic [1:0] gap_ff;
    // One unit every other cycle while DMARQ is held, every fourth when slow; ack never repeats back to back so a stale pulse cannot leak
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gap_ff <= 2'h0;
            dma_ack <= 1'b0;
        end else begin
            gap_ff <= gap_ff + 2'h1;
            dma_ack <= armed && dmarq && !dma_ack && (!slow || gap_ff == 2'h3);
        end
    end
endmodule // qdc_host_dma
`default_nettype wire

// File: sim/tb_queued_dma_cmd_protocol.sv
// Self-checking bench for the queued DMA command sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_queued_dma_cmd_protocol;
    import qdc_pkg::*;
    logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, pkt_done = 0, overlapped = 0;
    logic service_cmd = 0, data_ready = 0, cmd_done = 0, cmd_abort = 0, release_req = 0;
    logic other_released = 0, other_ready = 0, dma_ack, host_armed = 0, host_slow = 0;
    logic intrq, dmarq, int_pending;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, st;
    logic [4:0] cmd_tag = 5'h00, state_out;
    logic [15:0] cmd_count = 16'h0003;
    int n_fail = 0, samples_checked = 0;

    qdc_dev dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pkt_done(pkt_done),
        .overlapped(overlapped), .service_cmd(service_cmd), .data_ready(data_ready),
        .cmd_tag(cmd_tag), .cmd_count(cmd_count), .cmd_done(cmd_done), .cmd_abort(cmd_abort),
        .release_req(release_req), .other_released(other_released),
        .other_ready(other_ready), .dma_ack(dma_ack), .intrq(intrq), .dmarq(dmarq),
        .int_pending(int_pending), .state_out(state_out));
    qdc_host_dma host (.clk(clk), .rst_n(rst_n), .armed(host_armed), .slow(host_slow),
        .dmarq(dmarq), .dma_ack(dma_ack));

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Waits at least one edge so a stale state is never mistaken for the target
    task automatic wait_st(input logic [4:0] s);
        int i;
        i = 0;
        do begin
            @(posedge clk);
            #1;
            i++;
        end while (state_out !== s && i < 40);
        cmp({3'h0, state_out}, {3'h0, s});
    endtask

    task automatic kick(input logic srv);
        @(posedge clk);
        pkt_done <= !srv;
        service_cmd <= srv;
        @(posedge clk);
        pkt_done <= 1'b0;
        service_cmd <= 1'b0;
    endtask

    task automatic t_irq_path();
        wr(4'h0, 8'h08);
        cmd_tag <= 5'h15;
        host_armed <= 1'b1;
        kick(1'b0);
        wait_st(QDC_PREP);
        cmp({7'h0, intrq}, 8'h00);
        repeat (40) @(posedge clk);
        rd(4'h1, st);
        cmp(st & 8'h88, 8'h80);
        data_ready <= 1'b1;
        wait_st(QDC_RDY_IRQ);
        cmp({6'h0, intrq, int_pending}, 8'h03);
        rd(4'h1, st);
        cmp(st & 8'h8B, 8'h09);
        wait_st(QDC_XFER);
        cmp({5'h0, intrq, int_pending, dmarq}, 8'h01);
        @(posedge clk) data_ready <= 1'b0;
        rd(4'h2, st);
        cmp(st, 8'h15);
        wait_st(QDC_PREP);
        @(posedge clk) cmd_done <= 1'b1;
        wait_st(QDC_IDLE);
        cmp({7'h0, int_pending}, 8'h01);
        @(posedge clk) cmd_done <= 1'b0;
        rd(4'h1, st);
        cmp(st, 8'h03);
    endtask

    task automatic t_overlap();
        wr(4'h0, 8'h03);
        overlapped <= 1'b1;
        kick(1'b0);
        wait_st(QDC_REL_IDLE);
        cmp({7'h0, intrq}, 8'h00);
        overlapped <= 1'b0;
        rd(4'h1, st);
        cmp(st & 8'h84, 8'h04);
    endtask

    // Polled transfer with a slow host, then release with another command ready
    task automatic t_poll_release();
        wr(4'h0, 8'h01);
        data_ready <= 1'b1;
        cmd_tag <= 5'h0A;
        host_slow <= 1'b1;
        kick(1'b0);
        wait_st(QDC_XFER);
        cmp({5'h0, intrq, int_pending, dmarq}, 8'h03);
        @(posedge clk) data_ready <= 1'b0;
        rd(4'h1, st);
        cmp(st & 8'h8F, 8'h08);
        wait_st(QDC_PREP);
        rd(4'h1, st);
        rd(4'h1, st);
        cmp(st & 8'h88, 8'h80);
        cmp({7'h0, dmarq}, 8'h00);
        @(posedge clk) release_req <= 1'b1;
        other_ready <= 1'b1;
        wait_st(QDC_REL_IDLE);
        cmp({7'h0, intrq}, 8'h00);
        @(posedge clk) release_req <= 1'b0;
        other_ready <= 1'b0;
        rd(4'h1, st);
        cmp(st & 8'h9F, 8'h17);
    endtask

    task automatic t_service();
        wr(4'h0, 8'h04);
        kick(1'b1);
        wait_st(QDC_RDY_IRQ);
        cmp({7'h0, intrq}, 8'h01);
        repeat (40) @(posedge clk);
        rd(4'h1, st);
        wait_st(QDC_PREP);
        @(posedge clk) cmd_abort <= 1'b1;
        other_released <= 1'b1;
        wait_st(QDC_REL_IDLE);
        cmp({7'h0, int_pending}, 8'h01);
        @(posedge clk) cmd_abort <= 1'b0;
        other_released <= 1'b0;
        rd(4'h1, st);
        cmp(st & 8'hBF, 8'h23);
        wr(4'h0, 8'h01);
        cmd_done <= 1'b1;
        other_ready <= 1'b1;
        kick(1'b0);
        wait_st(QDC_REL_IDLE);
        cmp({6'h0, intrq, int_pending}, 8'h00);
        @(posedge clk) cmd_done <= 1'b0;
        other_ready <= 1'b0;
        rd(4'h1, st);
        cmp(st & 8'h9F, 8'h13);
        rd(4'hF, st);
        cmp(st, 8'h00);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence after an eight-cycle reset
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        wait_st(QDC_IDLE);
        t_irq_path();
        t_overlap();
        t_poll_release();
        t_service();
        report_and_stop();
    end

    // Whole run needs under two hundred cycles; this limit cuts a hang short
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
endmodule // tb_queued_dma_cmd_protocol
`default_nettype wire
